// [verilog/mcbw_pkg.sv]
package mcbw_pkg;

    // Clock and timing
    localparam int unsigned    CLK_MHZ         = 125;
    localparam int unsigned    INACT_MIN       = 4;
    localparam longint unsigned INACT_CYC      = 64'(INACT_MIN) * 64'd60 * 64'd1000000 * 64'(CLK_MHZ);
    localparam int unsigned    WK_FILTER_NS    = 1000;
    localparam int unsigned    WK_FILTER_CYC   = (WK_FILTER_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned    WK_TIMEOUT_US   = 1000;
    localparam int unsigned    WK_TIMEOUT_CYC  = WK_TIMEOUT_US * CLK_MHZ;

    // Register map
    localparam int unsigned    AXI_AW          = 8;
    localparam logic [7:0]     REG_CTRL        = 8'h00;
    localparam logic [7:0]     REG_STATUS      = 8'h04;
    localparam logic [7:0]     REG_FLAGS       = 8'h08;
    localparam logic [7:0]     REG_MASK        = 8'h0C;
    localparam logic [1:0]     RESP_OKAY       = 2'h0;
    localparam logic [1:0]     RESP_SLVERR     = 2'h2;

    // Control fields
    localparam int unsigned    CTL_MODE_LSB    = 0;
    localparam int unsigned    CTL_SWT_DIS     = 4;
    localparam int unsigned    CTL_WKRQ_IRQ    = 5;
    localparam int unsigned    CTL_TEST        = 6;
    localparam int unsigned    CTL_WDACT_LSB   = 8;
    localparam int unsigned    CTL_WDTRIG      = 10;
    localparam logic [1:0]     SEL_STANDBY     = 2'h1;
    localparam logic [1:0]     SEL_NORMAL      = 2'h2;
    localparam logic [1:0]     SEL_SLEEP       = 2'h3;
    localparam logic [1:0]     WDACT_RST       = 2'h0;
    localparam logic [1:0]     WDACT_IRQ       = 2'h0;
    localparam logic [1:0]     WDACT_STANDBY   = 2'h1;

    // Status fields
    localparam int unsigned    STS_MODE_LSB    = 0;
    localparam int unsigned    STS_BUS_WAKE_INDICATION        = 3;
    localparam int unsigned    STS_INACT       = 4;

    // Flag bits
    localparam int unsigned    NFLAGS          = 8;
    localparam int unsigned    FL_PWRON        = 0;
    localparam int unsigned    FL_BUS_WAKE     = 1;
    localparam int unsigned    FL_LOCAL_WAKE   = 2;
    localparam int unsigned    FL_IO_UV        = 3;
    localparam int unsigned    FL_LDO_UV       = 4;
    localparam int unsigned    FL_TSD          = 5;
    localparam int unsigned    FL_SLEEP_FAULT  = 6;
    localparam int unsigned    FL_WD           = 7;
    localparam logic [7:0]     FLAGS_RST       = 8'h01;
    localparam logic [7:0]     MASK_RST        = 8'h00;
    localparam logic [7:0]     SLEEP_KEEP      = 8'h40;
    localparam logic [7:0]     WAKE_BITS       = 8'h06;

    typedef enum logic [2:0] {MD_STANDBY, MD_NORMAL, MD_SLEEP, MD_TSD_PROT, MD_UV_PROT} mcbw_mode_t;
    typedef enum logic [2:0] {WK_IDLE, WK_REC, WK_DOM2, WK_BUS_WAKE_INDICATION, WK_WAIT_REC} mcbw_wk_t;

endpackage

// [verilog/mcbw_top.sv]
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
// How it works
// - Wake events move sleep to standby alone
// - Host selects normal, standby or sleep
// - Normal mode passes transmit and receive
// - Standby blocks transmit and normal receive
// - Standby keeps wake watch, bus, inhibit on
// - Wake request held low through standby unless the wake-request interrupt bit is set
// - One wake interrupt per sleep entry or normal-to-standby entry
// - After undervoltage, normal needs a cleared undervoltage flag
// - Power-up or wake starts inactivity timer
// - Inactivity expiry in standby returns sleep
// - Timer disable bit affects sleep wakes only
// - Sleep disables bus, inhibit, wipes config
// - Only wake or reset ends sleep
// - Fault-forced sleep sets sleep-cause bit
// - Bus wake raises interrupt and wake request
// - Pattern: dominant, recessive, dominant, all filtered
// - Short activity between phases is ignored
// - Indication drives receive low past filter
// - States under filter time never count
// - Pattern timeout waits recessive then restarts
// - Test mode keeps watchdog actions 00, 01
module mcbw_top
    import mcbw_pkg::*;
#(
    parameter int unsigned     FILT_CYC  = WK_FILTER_CYC,
    parameter int unsigned     TOUT_CYC  = WK_TIMEOUT_CYC,
    parameter longint unsigned INACT_LEN = INACT_CYC
) (
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           rstn,
    // AXI4-Lite write address
    input  wire logic                           s_axi_awvalid,
    output      logic                           s_axi_awready,
    input  wire logic [mcbw_pkg::AXI_AW-1:0]    s_axi_awaddr,
    input  wire logic [2:0]                     s_axi_awprot,
    // AXI4-Lite write data and response
    input  wire logic                           s_axi_wvalid,
    output      logic                           s_axi_wready,
    input  wire logic [31:0]                    s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    output      logic                           s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    output      logic [1:0]                     s_axi_bresp,
    // AXI4-Lite read
    input  wire logic                           s_axi_arvalid,
    output      logic                           s_axi_arready,
    input  wire logic [mcbw_pkg::AXI_AW-1:0]    s_axi_araddr,
    input  wire logic [2:0]                     s_axi_arprot,
    output      logic                           s_axi_rvalid,
    input  wire logic                           s_axi_rready,
    output      logic [31:0]                    s_axi_rdata,
    output      logic [1:0]                     s_axi_rresp,
    // Bus side and controller side
    input  wire logic                           bus_rx_dominant,
    output      logic                           bus_tx_dominant,
    input  wire logic                           ctrl_tx,
    output      logic                           ctrl_rx,
    // Events and supplies
    input  wire logic                           local_pin_wake,
    input  wire logic                           io_supply_undervoltage,
    input  wire logic                           ldo_output_undervoltage,
    input  wire logic                           thermal_shutdown,
    input  wire logic                           wd_timeout,
    // Pins and watchdog control
    output      logic                           global_irq_out_n,
    output      logic                           wake_request_out_n,
    output      logic                           regulator_inhibit_out,
    output      logic                           watchdog_run,
    output      logic                           watchdog_trigger_bit,
    output      logic [1:0]                     watchdog_timeout_action
);
    import mcbw_pkg::*;

    mcbw_mode_t         mode_q;
    mcbw_wk_t           wk_q;
    logic               aw_have_q;
    logic               w_have_q;
    logic [AXI_AW-1:0]  awaddr_q;
    logic [31:0]        wdata_q;
    logic [3:0]         wstrb_q;
    logic               bvalid_q;
    logic [1:0]         bresp_q;
    logic               rvalid_q;
    logic [31:0]        rdata_q;
    logic [1:0]         rresp_q;
    logic               swt_dis_q;
    logic               wkrq_irq_q;
    logic               test_q;
    logic [1:0]         wdact_q;
    logic [NFLAGS-1:0]  flags_q;
    logic [NFLAGS-1:0]  flags_d;
    logic [NFLAGS-1:0]  mask_q;
    logic [NFLAGS-1:0]  fl_set;
    logic [NFLAGS-1:0]  fl_clr;
    logic               wake_armed_q;
    logic               inact_run_q;
    logic [39:0]        inact_cnt_q;
    logic               bus_prev_q;
    logic [31:0]        run_cnt_q;
    logic [31:0]        tout_cnt_q;
    logic               io_uv_prev_q;
    logic               wd_pulse_q;
    logic               wr_fire;
    logic               wr_ok;
    logic               wr_ctrl;
    logic               wr_flags;
    logic               wr_mask;
    logic               host_sel;
    logic [1:0]         sel;
    logic               same_state;
    logic               filt_hit;
    logic               wup_hit;
    logic               det_on;
    logic               det_clear;
    logic               wake_ev;
    logic               uv_ev;
    logic               inact_exp;
    logic               to_sleep;
    logic               sleep_fault;
    logic               standby_entry;
    logic [31:0]        rd_data;
    logic               rd_ok;

    // AXI4-Lite slave: address and data taken independently, answer after both
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready  = !w_have_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    assign wr_fire  = aw_have_q && w_have_q && !bvalid_q;
    assign wr_ok    = wr_fire && (mode_q != MD_SLEEP) && (mode_q != MD_UV_PROT);
    assign wr_ctrl  = wr_ok && (awaddr_q == REG_CTRL);
    assign wr_flags = wr_ok && (awaddr_q == REG_FLAGS) && wstrb_q[0];
    assign wr_mask  = wr_ok && (awaddr_q == REG_MASK) && wstrb_q[0];
    assign host_sel = wr_ctrl && wstrb_q[0];
    assign sel      = wdata_q[CTL_MODE_LSB +: 2];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aw_have_q <= 1'b0;
            awaddr_q  <= '0;
        end else if (s_axi_awvalid && !aw_have_q) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            w_have_q <= 1'b0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end else if (s_axi_wvalid && !w_have_q) begin
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wr_ok && (awaddr_q == REG_CTRL || awaddr_q == REG_FLAGS || awaddr_q == REG_MASK ||
                         awaddr_q == REG_STATUS)) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_comb begin
        rd_data = '0;
        rd_ok   = (mode_q != MD_SLEEP) && (mode_q != MD_UV_PROT);
        case (s_axi_araddr)
            REG_CTRL: begin
                rd_data[CTL_SWT_DIS]            = swt_dis_q;
                rd_data[CTL_WKRQ_IRQ]           = wkrq_irq_q;
                rd_data[CTL_TEST]               = test_q;
                rd_data[CTL_WDACT_LSB +: 2]     = wdact_q;
            end
            REG_STATUS: begin
                rd_data[STS_MODE_LSB +: 3]      = mode_q;
                rd_data[STS_BUS_WAKE_INDICATION]               = (wk_q == WK_BUS_WAKE_INDICATION);
                rd_data[STS_INACT]              = inact_run_q;
            end
            REG_FLAGS: rd_data[NFLAGS-1:0]      = flags_q;
            REG_MASK:  rd_data[NFLAGS-1:0]      = mask_q;
            default:   rd_ok                    = 1'b0;
        endcase
        if (!rd_ok) begin
            rd_data = '0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_data;
            rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Bus wake detector: run counter measures how long the bus holds one state
    assign same_state = (bus_rx_dominant == bus_prev_q);
    assign filt_hit   = same_state && (run_cnt_q == 32'(FILT_CYC - 1));
    assign wup_hit    = (wk_q == WK_DOM2) && filt_hit && bus_rx_dominant;
    assign det_on     = (mode_q != MD_NORMAL);
    assign uv_ev      = io_supply_undervoltage && !io_uv_prev_q;
    assign det_clear  = !det_on || uv_ev;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus_prev_q <= 1'b0;
            run_cnt_q  <= '0;
        end else begin
            bus_prev_q <= bus_rx_dominant;
            if (!same_state) begin
                run_cnt_q <= '0;
            end else if (run_cnt_q != 32'hFFFFFFFF) begin
                run_cnt_q <= run_cnt_q + 32'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wk_q       <= WK_IDLE;
            tout_cnt_q <= '0;
        end else if (det_clear) begin
            wk_q       <= WK_IDLE;
            tout_cnt_q <= '0;
        end else begin
            if (wk_q == WK_REC || wk_q == WK_DOM2) begin
                tout_cnt_q <= tout_cnt_q + 32'h1;
            end else begin
                tout_cnt_q <= '0;
            end
            case (wk_q)
                WK_IDLE:     if (filt_hit && bus_rx_dominant) wk_q <= WK_REC;
                WK_REC: begin
                    if (tout_cnt_q >= 32'(TOUT_CYC - 1)) wk_q <= WK_WAIT_REC;
                    else if (filt_hit && !bus_rx_dominant) wk_q <= WK_DOM2;
                end
                WK_DOM2: begin
                    if (tout_cnt_q >= 32'(TOUT_CYC - 1)) wk_q <= WK_WAIT_REC;
                    else if (wup_hit) wk_q <= WK_BUS_WAKE_INDICATION;
                end
                WK_WAIT_REC: if (filt_hit && !bus_rx_dominant) wk_q <= WK_IDLE;
                WK_BUS_WAKE_INDICATION:     wk_q <= WK_BUS_WAKE_INDICATION;
                default:     wk_q <= WK_IDLE;
            endcase
        end
    end

    // Receive, transmit paths; registered, so one cycle of latency each way
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus_tx_dominant <= 1'b0;
            ctrl_rx         <= 1'b1;
        end else begin
            bus_tx_dominant <= (mode_q == MD_NORMAL) && !ctrl_tx;
            if (mode_q == MD_NORMAL) begin
                ctrl_rx <= !bus_rx_dominant;
            end else begin
                ctrl_rx <= !((wk_q == WK_BUS_WAKE_INDICATION || wup_hit) && bus_rx_dominant &&
                             (run_cnt_q >= 32'(FILT_CYC - 1)));
            end
        end
    end

    // Mode control
    // wake leaves sleep alone
    assign wake_ev       = (mode_q == MD_SLEEP) && (wup_hit || local_pin_wake);
    assign inact_exp     = inact_run_q && (mode_q == MD_STANDBY) && (inact_cnt_q >= 40'(INACT_LEN - 1));
    assign sleep_fault   = inact_exp;
    assign to_sleep      = (mode_q != MD_SLEEP) && (mode_q != MD_UV_PROT) && !uv_ev && !thermal_shutdown &&
                           (inact_exp || (host_sel && sel == SEL_SLEEP));
    assign standby_entry = wake_ev || (mode_q == MD_NORMAL && host_sel && sel == SEL_STANDBY) ||
                           (mode_q == MD_NORMAL && wd_timeout && wdact_q == WDACT_STANDBY);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= MD_STANDBY;
        end else begin
            case (mode_q)
                MD_STANDBY, MD_NORMAL: begin
                    if (uv_ev) mode_q <= MD_UV_PROT;
                    else if (thermal_shutdown) mode_q <= MD_TSD_PROT;
                    else if (to_sleep) mode_q <= MD_SLEEP;
                    else if (standby_entry) mode_q <= MD_STANDBY;
                    else if (host_sel && sel == SEL_NORMAL && !flags_q[FL_IO_UV]) mode_q <= MD_NORMAL;
                end
                MD_TSD_PROT: if (!thermal_shutdown) mode_q <= MD_STANDBY;
                MD_UV_PROT:  if (!io_supply_undervoltage) mode_q <= MD_STANDBY;
                MD_SLEEP:    if (wake_ev) mode_q <= MD_STANDBY;
                default:     mode_q <= MD_STANDBY;
            endcase
        end
    end

    // Inactivity window: runs from reset, and from sleep wakes unless disabled
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            inact_run_q <= 1'b1;
            inact_cnt_q <= '0;
        end else if (wake_ev) begin
            inact_run_q <= !swt_dis_q;
            inact_cnt_q <= '0;
        end else if (to_sleep || (wr_flags && |wdata_q[NFLAGS-1:0]) ||
                     (host_sel && sel == SEL_NORMAL && !flags_q[FL_IO_UV])) begin
            inact_run_q <= 1'b0;
            inact_cnt_q <= '0;
        end else if (inact_run_q && mode_q == MD_STANDBY) begin
            inact_cnt_q <= inact_cnt_q + 40'h1;
        end
    end

    // Configuration, wiped on sleep entry except the timer disable bit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            swt_dis_q  <= 1'b0;
            wkrq_irq_q <= 1'b0;
            test_q     <= 1'b0;
            wdact_q    <= WDACT_RST;
            mask_q     <= MASK_RST;
        end else if (to_sleep) begin
            wkrq_irq_q <= 1'b0;
            test_q     <= 1'b0;
            wdact_q    <= WDACT_RST;
            mask_q     <= MASK_RST;
        end else begin
            if (host_sel) begin
                swt_dis_q  <= wdata_q[CTL_SWT_DIS];
                wkrq_irq_q <= wdata_q[CTL_WKRQ_IRQ];
                test_q     <= wdata_q[CTL_TEST];
            end
            if (wr_ctrl && wstrb_q[1] && (!(wstrb_q[0] ? wdata_q[CTL_TEST] : test_q) ||
                                         !wdata_q[CTL_WDACT_LSB + 1])) begin
                wdact_q <= wdata_q[CTL_WDACT_LSB +: 2];
            end
            if (wr_mask) begin
                mask_q <= wdata_q[NFLAGS-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            watchdog_trigger_bit <= 1'b0;
        end else begin
            watchdog_trigger_bit <= wr_ctrl && wstrb_q[1] && wdata_q[CTL_WDTRIG];
        end
    end

    // Flags: set wins over a same-cycle clear
    // one wake interrupt per entry
    always_comb begin
        fl_set                 = '0;
        fl_set[FL_BUS_WAKE]    = wake_armed_q && wup_hit && (mode_q == MD_SLEEP || mode_q == MD_STANDBY);
        fl_set[FL_LOCAL_WAKE]  = wake_armed_q && local_pin_wake && (mode_q == MD_SLEEP || mode_q == MD_STANDBY);
        fl_set[FL_IO_UV]       = uv_ev;
        fl_set[FL_LDO_UV]      = ldo_output_undervoltage;
        fl_set[FL_TSD]         = thermal_shutdown;
        fl_set[FL_SLEEP_FAULT] = sleep_fault;
        fl_set[FL_WD]          = wd_timeout && (mode_q == MD_STANDBY || mode_q == MD_NORMAL || mode_q == MD_TSD_PROT);
        fl_clr                 = wr_flags ? wdata_q[NFLAGS-1:0] : '0;
        flags_d                = flags_q & ~fl_clr;
        if (to_sleep) begin
            flags_d = flags_d & SLEEP_KEEP;
        end
        flags_d = flags_d | fl_set;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags_q      <= FLAGS_RST;
            io_uv_prev_q <= 1'b0;
        end else begin
            flags_q      <= flags_d;
            io_uv_prev_q <= io_supply_undervoltage;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wake_armed_q <= 1'b1;
        end else if (to_sleep || (mode_q == MD_NORMAL && standby_entry)) begin
            wake_armed_q <= 1'b1;
        end else if (fl_set[FL_BUS_WAKE] || fl_set[FL_LOCAL_WAKE]) begin
            wake_armed_q <= 1'b0;
        end
    end

    // Pins, driven from flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            global_irq_out_n      <= 1'b0;
            wake_request_out_n    <= 1'b0;
            regulator_inhibit_out <= 1'b1;
            watchdog_run          <= 1'b0;
            wd_pulse_q            <= 1'b0;
        end else begin
            wd_pulse_q <= wd_timeout && wdact_q == WDACT_STANDBY;
            global_irq_out_n      <= (mode_q == MD_SLEEP || mode_q == MD_UV_PROT) ? 1'b1 :
                                     !(|(flags_d & ~mask_q));
            if (mode_q == MD_SLEEP && !wake_ev) begin
                wake_request_out_n <= 1'b1;
            end else if (wkrq_irq_q) begin
                wake_request_out_n <= !(|(flags_d & ~mask_q & WAKE_BITS));
            end else begin
                wake_request_out_n <= 1'b0;
            end
            regulator_inhibit_out <= (mode_q != MD_SLEEP) && (mode_q != MD_UV_PROT) && !to_sleep && !wd_pulse_q;
            watchdog_run          <= (mode_q != MD_SLEEP) && (mode_q != MD_UV_PROT);
        end
    end

    assign watchdog_timeout_action = wdact_q;

endmodule // mcbw_top

// [verification/mcbw_bus_model.sv]
`timescale 1ns/100ps
module mcbw_bus_model (
    input  wire logic clk,
    output      logic bus_rx_dominant
);
    // Bus idles recessive, as the weak bias pulls it
    initial bus_rx_dominant = 1'h0;
    task automatic phase(input logic dom, input int n);
        bus_rx_dominant <= dom;
        repeat (n) @(posedge clk);
    endtask
endmodule // mcbw_bus_model

// [verification/mcbw_top_asserts.sv]
`timescale 1ns/100ps
module mcbw_asserts (
    input wire logic        clk, rstn, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic        s_axi_bvalid, s_axi_bready, bus_rx_dominant, bus_tx_dominant, ctrl_tx,
    input wire logic        ctrl_rx, global_irq_out_n, wake_request_out_n, regulator_inhibit_out,
    input wire logic        watchdog_run, watchdog_trigger_bit, io_supply_undervoltage,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_bresp
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    tx_cause_a: assert property (bus_tx_dominant |-> !$past(ctrl_tx))
        else $error("bus driven without cause");
    rx_cause_a: assert property (!ctrl_rx |-> $past(bus_rx_dominant))
        else $error("receive low without bus");
    sleep_off_a: assert property ((!regulator_inhibit_out && !io_supply_undervoltage)[*4]
        |-> !watchdog_run && $past(wake_request_out_n)) else $error("sleep pins wrong");
    wake_pins_a: assert property ($rose(regulator_inhibit_out)
        |-> ##[0:3] (!global_irq_out_n && !wake_request_out_n)) else $error("wake not signalled");
    trig_pulse_a: assert property (watchdog_trigger_bit |=> !watchdog_trigger_bit)
        else $error("trigger not a pulse");
endmodule // mcbw_asserts
bind mcbw_top mcbw_asserts u_chk (.*);

// [verification/testbench.sv]
`timescale 1ns/100ps
module testbench;
    import mcbw_pkg::*;
    localparam int INL = 200;
    logic clk = 0, rstn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, ctrl_tx = 1, local_pin_wake = 0, io_supply_undervoltage = 0;
    logic thermal_shutdown = 0, wd_timeout = 0;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, bus_tx_dominant, ctrl_rx;
    wire logic global_irq_out_n, wake_request_out_n, regulator_inhibit_out, watchdog_run, watchdog_trigger_bit;
    wire logic bus_rx_dominant;
    wire logic [1:0] s_axi_bresp, s_axi_rresp, watchdog_timeout_action;
    wire logic [31:0] s_axi_rdata;
    wire logic ldo_output_undervoltage = io_supply_undervoltage;
    logic [65:0] q[$], e;
    int fails = 0, check_count = 0, cyc = 0;
    logic [1:0] rv;
    always #4 clk = ~clk;
    mcbw_bus_model bus (.clk(clk), .bus_rx_dominant(bus_rx_dominant));
    mcbw_top #(.FILT_CYC(4), .TOUT_CYC(64), .INACT_LEN(INL)) DUT (.*);
    task automatic chk(input logic [33:0] g, x);
        check_count++;
        if (g !== x) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic pin(input logic g, x);
        chk({33'h0, g}, {33'h0, x});
    endtask
    // Entry is {resp, mask, data}; handshakes judged at the falling edge to avoid races
    task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [65:0] x);
        logic [2:0] h;
        @(posedge clk);
        q.push_back(x);
        if (w) begin s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1; end
        else begin s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1; end
        forever begin
            @(negedge clk);
            h = w ? {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid}
                  : {s_axi_arvalid & s_axi_arready, 1'h0, s_axi_rvalid};
            @(posedge clk);
            if (h[2]) begin s_axi_awvalid <= 0; s_axi_arvalid <= 0; end
            if (h[1]) s_axi_wvalid <= 0;
            if (h[0]) begin s_axi_bready <= 0; s_axi_rready <= 0; break; end
        end
    endtask
    always @(posedge clk) if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
        e = q.pop_front();
        chk(s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata & e[63:32]}, {e[65:64], e[31:0]});
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin fails++; complete_run(); end
    end
    task automatic wake_pulse;
        local_pin_wake <= 1;
        @(posedge clk);
        local_pin_wake <= 0;
        repeat (3) @(posedge clk);
    endtask
    initial begin
        void'($urandom(78191));
        repeat (4) @(posedge clk);
        rstn <= 1;
        axi(0, REG_STATUS, 0, {RESP_OKAY, 32'h1F, 32'h10});
        axi(0, REG_FLAGS, 0, {RESP_OKAY, 32'hFF, 32'h01});
        axi(0, 8'h10, 0, {RESP_SLVERR, 32'hFFFFFFFF, 32'h0});
        repeat (INL) @(posedge clk);
        pin(regulator_inhibit_out, 0);
        axi(0, REG_FLAGS, 0, {RESP_SLVERR, 32'hFFFFFFFF, 32'h0});
        bus.phase(1, 6); bus.phase(0, 75); bus.phase(1, 6); bus.phase(0, 6);
        pin(regulator_inhibit_out, 0);
        bus.phase(1, 6); bus.phase(0, 2); bus.phase(1, 2); bus.phase(0, 6);
        bus.phase(1, 2); bus.phase(0, 3); bus.phase(1, 6); bus.phase(0, 4);
        pin(regulator_inhibit_out, 1);
        pin(wake_request_out_n, 0);
        pin(global_irq_out_n, 0);
        axi(0, REG_FLAGS, 0, {RESP_OKAY, 32'hFF, 32'h42});
        bus.phase(1, 8);
        pin(ctrl_rx, 0);
        bus.phase(0, 4);
        pin(ctrl_rx, 1);
        axi(1, REG_FLAGS, 32'hFF, {RESP_OKAY, 64'h0});
        wake_pulse();
        axi(0, REG_FLAGS, 0, {RESP_OKAY, 32'hFF, 32'h00});
        axi(1, REG_CTRL, 32'h502, {RESP_OKAY, 64'h0});
        pin(watchdog_trigger_bit, 1);
        axi(0, REG_STATUS, 0, {RESP_OKAY, 32'hF, 32'h1});
        // Random traffic through the transceiver path in normal mode
        repeat (30) begin
            rv = {ctrl_tx, bus_rx_dominant};
            ctrl_tx <= 1'($urandom); bus.phase(1'($urandom), 1);
            pin(bus_tx_dominant, !rv[1]); pin(ctrl_rx, !rv[0]);
        end
        ctrl_tx <= 1;
        bus.phase(0, 2);
        wd_timeout <= 1; @(posedge clk); wd_timeout <= 0;
        axi(0, REG_STATUS, 0, {RESP_OKAY, 32'h7, 32'h0});
        io_supply_undervoltage <= 1;
        repeat (5) @(posedge clk);
        io_supply_undervoltage <= 0;
        repeat (4) @(posedge clk);
        thermal_shutdown <= 1; axi(0, REG_STATUS, 0, {RESP_OKAY, 32'h7, 32'h3});
        thermal_shutdown <= 0;
        axi(1, REG_CTRL, 32'h2, {RESP_OKAY, 64'h0});
        axi(0, REG_STATUS, 0, {RESP_OKAY, 32'h7, 32'h0});
        axi(1, REG_FLAGS, 32'hFF, {RESP_OKAY, 64'h0});
        axi(1, REG_CTRL, 32'h2, {RESP_OKAY, 64'h0});
        axi(0, REG_STATUS, 0, {RESP_OKAY, 32'h7, 32'h1});
        axi(1, REG_MASK, 32'h10, {RESP_OKAY, 64'h0});
        axi(1, REG_CTRL, 32'h10, {RESP_OKAY, 64'h0});
        axi(1, REG_CTRL, 32'h3, {RESP_OKAY, 64'h0});
        repeat (6) @(posedge clk);
        pin(regulator_inhibit_out, 0);
        wake_pulse();
        pin(regulator_inhibit_out, 1);
        axi(0, REG_STATUS, 0, {RESP_OKAY, 32'h1F, 32'h0});
        complete_run();
    end
endmodule // testbench
